// ===== src/usb_core_pkg.sv
package usb_core_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam logic [11:0] CORE_RESET_CONTROL_OFFSET = 12'h010;
	localparam logic [11:0] CORE_INTERRUPT_STATUS_OFFSET = 12'h014;
	localparam logic [31:0] CORE_RESET_CONTROL_RESET = 32'h80000000;
	localparam logic [31:0] CORE_INTERRUPT_STATUS_RESET = 32'h00000020;

	// ----------------------------------------------------------------
	// Reset control fields
	// ----------------------------------------------------------------
	localparam int BUS_MASTER_IDLE_BIT = 31;
	localparam int DMA_REQUEST_BIT = 30;
	localparam int TX_SELECT_LSB = 6;
	localparam int TX_SELECT_MSB = 10;
	localparam int TX_FLUSH_BIT = 5;
	localparam int RX_FLUSH_BIT = 4;
	localparam int TOKEN_QUEUE_FLUSH_BIT = 3;
	localparam int BUS_RESET_BIT = 1;
	localparam int CORE_RESET_BIT = 0;
	localparam logic [4:0] TX_FLUSH_ALL = 5'h10;
	localparam logic [4:0] TX_SELECT_RESET = 5'h00;

	// ----------------------------------------------------------------
	// Interrupt status fields
	// ----------------------------------------------------------------
	localparam int WAKEUP_BIT = 31;
	localparam int SESSION_REQUEST_BIT = 30;
	localparam int CONN_ID_CHANGE_BIT = 28;
	localparam int SUSPEND_RESET_BIT = 23;
	localparam int FETCH_SUSPENDED_BIT = 22;
	localparam int ISO_OUT_BIT = 21;
	localparam int ISO_IN_BIT = 20;
	localparam int OUT_EP_PENDING_BIT = 19;
	localparam int IN_EP_PENDING_BIT = 18;
	localparam int PERIODIC_FRAME_BIT = 15;
	localparam logic [31:0] STATUS_STICKY_MASK = 32'hD0F08000;

	// ----------------------------------------------------------------
	// Self-clearing timers
	// ----------------------------------------------------------------
	localparam int FLUSH_CLOCKS = 8;
	localparam int NUM_TIMERS = 5;
	localparam int T_TX = 0;
	localparam int T_RX = 1;
	localparam int T_TKQ = 2;
	localparam int T_BUS = 3;
	localparam int T_CORE = 4;

	typedef enum logic {
		T_IDLE,
		T_RUN
	} timer_state_t;

endpackage

// ===== src/flush_if.sv
`timescale 1ns/1ps
`default_nettype none

interface flush_if;
	logic start;
	logic phy_tick;
	logic ready;
	logic busy;

	modport ctrl(output start, output phy_tick, output ready, input busy);
	modport timer(input start, input phy_tick, input ready, output busy);
endinterface

`default_nettype wire

// ===== src/sync3.sv
`timescale 1ns/1ps
`default_nettype none

module sync3 #(
	parameter int WIDTH = 1
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] ff1_reg;
	logic [WIDTH-1:0] ff2_reg;
	logic [WIDTH-1:0] ff3_reg;
	wire [WIDTH-1:0] agree = ~(ff2_reg ^ ff3_reg);
	wire [WIDTH-1:0] dout_next = (ff2_reg & agree) | (dout & ~agree);

	if (WIDTH < 1) begin : g_bad_width
		$error("sync3 needs WIDTH of at least one");
	end

	// A change is taken only once the second and third stages agree.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ff1_reg <= '0;
			ff2_reg <= '0;
			ff3_reg <= '0;
			dout <= '0;
		end else begin
			ff1_reg <= din;
			ff2_reg <= ff1_reg;
			ff3_reg <= ff2_reg;
			dout <= dout_next;
		end
	end
endmodule

`default_nettype wire

// ===== src/flush_timer.sv
`timescale 1ns/1ps
`default_nettype none

module flush_timer
	import usb_core_pkg::*;
#(
	parameter int COUNT = FLUSH_CLOCKS
) (
	input wire logic clk_sys,
	input wire logic rst,
	flush_if.timer fl
);
	localparam int CW = $clog2(COUNT + 1);
	localparam logic [CW-1:0] LAST = CW'(COUNT);

	timer_state_t state_reg;
	logic [CW-1:0] sys_cnt_reg;
	logic [CW-1:0] phy_cnt_reg;
	logic busy_reg;

	if (COUNT < 1) begin : g_bad_count
		$error("flush_timer needs COUNT of at least one");
	end

	// Both the bus clock and the sampled PHY clock must each pass COUNT
	// cycles, so the slower of the two sets the length.
	wire sys_done = (sys_cnt_reg == LAST);
	wire phy_done = (phy_cnt_reg == LAST);
	wire finish = sys_done && phy_done && fl.ready;
	wire [CW-1:0] sys_cnt_next = sys_done ? sys_cnt_reg : sys_cnt_reg + 1'b1;
	wire [CW-1:0] phy_cnt_next = (phy_done || !fl.phy_tick) ? phy_cnt_reg : phy_cnt_reg + 1'b1;

	assign fl.busy = busy_reg;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_reg <= T_IDLE;
			sys_cnt_reg <= '0;
			phy_cnt_reg <= '0;
			busy_reg <= 1'b0;
		end else begin
			case (state_reg)
				T_IDLE: begin
					sys_cnt_reg <= '0;
					phy_cnt_reg <= '0;
					if (fl.start) begin
						state_reg <= T_RUN;
						busy_reg <= 1'b1;
					end
				end
				T_RUN: begin
					sys_cnt_reg <= sys_cnt_next;
					phy_cnt_reg <= phy_cnt_next;
					if (finish) begin
						state_reg <= T_IDLE;
						busy_reg <= 1'b0;
					end
				end
				default: begin
					state_reg <= T_IDLE;
					busy_reg <= 1'b0;
				end
			endcase
		end
	end

	chk_busy_min_length: assert property (
		@(posedge clk_sys) disable iff (rst)
		$rose(busy_reg) |-> busy_reg[*8]
	) else $error("self-clearing bit dropped before eight cycles");

	chk_clear_needs_ready: assert property (
		@(posedge clk_sys) disable iff (rst)
		$fell(busy_reg) |-> $past(fl.ready) && $past(phy_done)
	) else $error("self-clearing bit dropped without ready and PHY count");
endmodule

`default_nettype wire

// ===== src/usb_core_reset_int.sv
// Functional notes
// - Reset control top bit reads whether the bus master machine is idle.
// - A read-only bit shows whether a DMA request is in progress.
// - Five-bit select picks one transmit FIFO; 0x10 flushes all of them.
// - Transmit flush bit flushes selection, clears after eight slower-clock cycles.
// - Receive flush bit flushes the whole receive FIFO, clears after eight.
// - Token queue flush bit flushes the IN token learning queue, self-clears.
// - Bus-domain reset resets bus-side logic only, no FIFO or status cleared.
// - Bus-domain reset bit self-clears when done; duration depends on state.
// - Core reset clears all status and control, keeping preserved bits elsewhere.
// - Core reset idles all machines but bus slave and flushes every FIFO.
// - Core reset ends master after data phase, aborts USB at once, self-clears.
// - Wakeup bit sets on resume from suspend, or L1 host resume or wakeup.
// - In device mode, session request sets when B-session-valid rises.
// - Connector ID change bit sets whenever connector ID changes.
// - Suspend reset bit sets only in device mode, suspended in partial power-down.
// - Fetch suspended bit sets only in DMA mode when IN fetching stalls.
// - Iso incomplete bits set together with end of periodic frame.
// - Endpoint pending bits follow any pending endpoint cause, read-only.
// - Interrupt output drives only while the global unmask is one.
// - A status bit reaches the interrupt only with its mask bit set.
`timescale 1ns/1ps
`default_nettype none

module usb_core_reset_int
	import usb_core_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	input wire logic phy_clk,
	input wire logic bsess_valid,
	input wire logic conn_id,
	input wire logic master_sm_idle,
	input wire logic dma_request_active,
	input wire logic device_mode,
	input wire logic dma_mode,
	input wire logic suspended,
	input wire logic partial_power_down,
	input wire logic l1_state,
	input wire logic resume_evt,
	input wire logic l1_wake_evt,
	input wire logic usb_reset_evt,
	input wire logic fetch_stall_evt,
	input wire logic iso_out_evt,
	input wire logic iso_in_evt,
	input wire logic periodic_frame_evt,
	input wire logic out_endpoint_cause_any,
	input wire logic in_endpoint_cause_any,
	input wire logic global_interrupt_unmask,
	input wire logic [31:0] int_mask,
	output logic irq,
	output logic tx_fifo_flush,
	output logic [4:0] tx_fifo_select,
	output logic rx_fifo_flush,
	output logic in_token_queue_flush,
	output logic bus_domain_soft_reset,
	output logic core_soft_reset,
	output logic master_stop,
	output logic usb_abort
);
	localparam int FLUSH_WAIT_MAX = 400;

	// ----------------------------------------------------------------
	// Pin sampling
	// ----------------------------------------------------------------
	logic [2:0] pins_s;
	logic phy_s_d_reg;
	logic bsess_d_reg;
	logic conn_d_reg;

	sync3 #(.WIDTH(3)) u_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.din({phy_clk, bsess_valid, conn_id}),
		.dout(pins_s)
	);

	wire phy_s = pins_s[2];
	wire bsess_s = pins_s[1];
	wire conn_s = pins_s[0];
	wire phy_tick = phy_s && !phy_s_d_reg;
	wire bsess_rise = bsess_s && !bsess_d_reg;
	wire conn_change = conn_s ^ conn_d_reg;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			phy_s_d_reg <= 1'b0;
			bsess_d_reg <= 1'b0;
			conn_d_reg <= 1'b0;
		end else begin
			phy_s_d_reg <= phy_s;
			bsess_d_reg <= bsess_s;
			conn_d_reg <= conn_s;
		end
	end

	// ----------------------------------------------------------------
	// Register decode
	// ----------------------------------------------------------------
	wire ctrl_sel = (reg_addr == CORE_RESET_CONTROL_OFFSET);
	wire stat_sel = (reg_addr == CORE_INTERRUPT_STATUS_OFFSET);
	wire ctrl_wr = reg_wr && ctrl_sel;
	wire stat_wr = reg_wr && stat_sel;

	// ----------------------------------------------------------------
	// Self-clearing control bits
	// ----------------------------------------------------------------
	logic [NUM_TIMERS-1:0] start_vec;
	logic [NUM_TIMERS-1:0] ready_vec;
	logic [NUM_TIMERS-1:0] busy_vec;
	wire tx_busy = busy_vec[T_TX];
	wire rx_busy = busy_vec[T_RX];
	wire core_busy = busy_vec[T_CORE];
	wire bus_busy = busy_vec[T_BUS];

	// A second write to a bit that is still set is absorbed; the running
	// count is not restarted, so software cannot stretch a flush forever.
	assign start_vec[T_TX] = ctrl_wr && reg_wdata[TX_FLUSH_BIT] && !tx_busy;
	assign start_vec[T_RX] = ctrl_wr && reg_wdata[RX_FLUSH_BIT] && !rx_busy;
	assign start_vec[T_TKQ] = ctrl_wr && reg_wdata[TOKEN_QUEUE_FLUSH_BIT] && !busy_vec[T_TKQ];
	assign start_vec[T_BUS] = ctrl_wr && reg_wdata[BUS_RESET_BIT] && !bus_busy;
	assign start_vec[T_CORE] = ctrl_wr && reg_wdata[CORE_RESET_BIT] && !core_busy;
	assign ready_vec[T_TX] = 1'b1;
	assign ready_vec[T_RX] = 1'b1;
	assign ready_vec[T_TKQ] = 1'b1;
	// Both resets hold until the bus master has wound down its transfer.
	assign ready_vec[T_BUS] = master_sm_idle;
	assign ready_vec[T_CORE] = master_sm_idle;

	for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_timer
		flush_if fl();
		assign fl.start = start_vec[i];
		assign fl.phy_tick = phy_tick;
		assign fl.ready = ready_vec[i];
		assign busy_vec[i] = fl.busy;
		flush_timer #(.COUNT(FLUSH_CLOCKS)) u_timer (
			.clk_sys(clk_sys),
			.rst(rst),
			.fl(fl.timer)
		);
	end

	// ----------------------------------------------------------------
	// Reset control register state
	// ----------------------------------------------------------------
	logic idle_flag_reg;
	logic dma_flag_reg;
	logic [4:0] tx_sel_reg;
	wire sel_load = ctrl_wr && !tx_busy;
	wire [4:0] tx_sel_next = core_busy ? TX_SELECT_RESET :
		(sel_load ? reg_wdata[TX_SELECT_MSB:TX_SELECT_LSB] : tx_sel_reg);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			idle_flag_reg <= CORE_RESET_CONTROL_RESET[BUS_MASTER_IDLE_BIT];
			dma_flag_reg <= 1'b0;
			tx_sel_reg <= TX_SELECT_RESET;
		end else begin
			idle_flag_reg <= master_sm_idle;
			dma_flag_reg <= dma_request_active;
			tx_sel_reg <= tx_sel_next;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt status
	// ----------------------------------------------------------------
	logic [31:0] stat_reg;
	logic [31:0] set_vec;

	always_comb begin
		set_vec = '0;
		set_vec[WAKEUP_BIT] = resume_evt || (l1_state && l1_wake_evt);
		set_vec[SESSION_REQUEST_BIT] = device_mode && bsess_rise;
		set_vec[CONN_ID_CHANGE_BIT] = conn_change;
		set_vec[SUSPEND_RESET_BIT] = device_mode && suspended && partial_power_down &&
			usb_reset_evt;
		set_vec[FETCH_SUSPENDED_BIT] = dma_mode && fetch_stall_evt;
		set_vec[ISO_OUT_BIT] = iso_out_evt;
		set_vec[ISO_IN_BIT] = iso_in_evt;
		set_vec[PERIODIC_FRAME_BIT] = periodic_frame_evt || iso_out_evt || iso_in_evt;
	end

	// The set term is applied after the clear, so an event landing in the
	// same cycle as a write of one survives.
	wire [31:0] clr_vec = stat_wr ? reg_wdata : 32'h00000000;
	wire [31:0] stat_next = core_busy ? 32'h00000000 :
		(((stat_reg & ~clr_vec) | set_vec) & STATUS_STICKY_MASK);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			stat_reg <= CORE_INTERRUPT_STATUS_RESET & STATUS_STICKY_MASK;
		end else begin
			stat_reg <= stat_next;
		end
	end

	logic [31:0] stat_view;
	always_comb begin
		stat_view = stat_reg | (CORE_INTERRUPT_STATUS_RESET & ~STATUS_STICKY_MASK);
		stat_view[OUT_EP_PENDING_BIT] = out_endpoint_cause_any;
		stat_view[IN_EP_PENDING_BIT] = in_endpoint_cause_any;
	end

	logic [31:0] ctrl_view;
	always_comb begin
		ctrl_view = 32'h00000000;
		ctrl_view[BUS_MASTER_IDLE_BIT] = idle_flag_reg;
		ctrl_view[DMA_REQUEST_BIT] = dma_flag_reg;
		ctrl_view[TX_SELECT_MSB:TX_SELECT_LSB] = tx_sel_reg;
		ctrl_view[TX_FLUSH_BIT] = tx_busy;
		ctrl_view[RX_FLUSH_BIT] = rx_busy;
		ctrl_view[TOKEN_QUEUE_FLUSH_BIT] = busy_vec[T_TKQ];
		ctrl_view[BUS_RESET_BIT] = bus_busy;
		ctrl_view[CORE_RESET_BIT] = core_busy;
	end

	wire [31:0] rd_mux = ctrl_sel ? ctrl_view : (stat_sel ? stat_view : 32'h00000000);
	wire irq_next = global_interrupt_unmask && |(stat_view & int_mask);

	// ----------------------------------------------------------------
	// Registered outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			reg_rdata <= 32'h00000000;
			irq <= 1'b0;
			tx_fifo_flush <= 1'b0;
			tx_fifo_select <= TX_SELECT_RESET;
			rx_fifo_flush <= 1'b0;
			in_token_queue_flush <= 1'b0;
			bus_domain_soft_reset <= 1'b0;
			core_soft_reset <= 1'b0;
			master_stop <= 1'b0;
			usb_abort <= 1'b0;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : reg_rdata;
			irq <= irq_next;
			tx_fifo_flush <= tx_busy || core_busy;
			tx_fifo_select <= core_busy ? TX_FLUSH_ALL : tx_sel_reg;
			rx_fifo_flush <= rx_busy || core_busy;
			in_token_queue_flush <= busy_vec[T_TKQ] || core_busy;
			bus_domain_soft_reset <= bus_busy || core_busy;
			core_soft_reset <= core_busy;
			// The master is only asked to stop; it finishes its data phase
			// and reports idle before either reset can complete.
			master_stop <= bus_busy || core_busy;
			usb_abort <= core_busy;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence s_tx_run;
		tx_busy[*8] ##[1:FLUSH_WAIT_MAX] !tx_busy;
	endsequence

	sequence s_rx_run;
		rx_busy[*8] ##[1:FLUSH_WAIT_MAX] !rx_busy;
	endsequence

	chk_idle_read_path: assert property (
		reg_rd && ctrl_sel |=> reg_rdata[BUS_MASTER_IDLE_BIT] == $past(idle_flag_reg)
	) else $error("idle flag not reflected on read");
	chk_dma_read_path: assert property (
		reg_rd && ctrl_sel |=> reg_rdata[DMA_REQUEST_BIT] == $past(dma_request_active, 2)
	) else $error("dma request flag not reflected on read");
	chk_select_held: assert property (
		$past(tx_busy) && tx_busy && !core_busy |-> $stable(tx_sel_reg)
	) else $error("flush select changed during flush");
	chk_tx_flush_self: assert property (
		start_vec[T_TX] |=> s_tx_run
	) else $error("transmit flush did not self-clear in time");
	chk_rx_flush_self: assert property (
		start_vec[T_RX] |=> s_rx_run
	) else $error("receive flush did not self-clear in time");
	chk_wakeup_sets: assert property (
		resume_evt && !core_busy |=> stat_reg[WAKEUP_BIT]
	) else $error("wakeup status not set");
	chk_session_sets: assert property (
		device_mode && bsess_rise && !core_busy |=> stat_reg[SESSION_REQUEST_BIT]
	) else $error("session request status not set");
	chk_suspend_reset_detected_device: assert property (
		$rose(stat_reg[SUSPEND_RESET_BIT]) |-> $past(device_mode)
	) else $error("suspend reset status set outside device mode");
	chk_irq_gated: assert property (
		!global_interrupt_unmask |=> !irq
	) else $error("interrupt driven while globally masked");
	chk_w1c_clear: assert property (
		stat_wr && reg_wdata[CONN_ID_CHANGE_BIT] && !conn_change |=> !stat_reg[CONN_ID_CHANGE_BIT]
	) else $error("write one did not clear status");
	chk_core_clears: assert property (
		core_busy |=> stat_reg == 32'h00000000 && usb_abort
	) else $error("core reset did not clear status or abort");
endmodule

`default_nettype wire

// ===== tb/phy_model.sv
`timescale 1ns/1ps
`default_nettype none

module phy_model (
	input wire logic want_bsess,
	input wire logic want_id,
	output logic phy_clk,
	output logic bsess_valid,
	output logic conn_id
);
	// The PHY supplies its clock continuously, so it runs free with an odd phase offset.
	initial begin
		phy_clk = 1'b0;
		#7;
		forever #32 phy_clk = ~phy_clk;
	end

	// Pin levels follow the requested state after a small analogue delay.
	assign #3 bsess_valid = want_bsess;
	assign #3 conn_id = want_id;
endmodule

`default_nettype wire

// ===== tb/usb_core_reset_int_bench.sv
`timescale 1ns/1ps
`default_nettype none

module usb_core_reset_int_bench
	import usb_core_pkg::*;
;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [11:0] reg_addr = 12'h000;
	logic [31:0] reg_wdata = 32'h0, int_mask = 32'h0, status_m = 32'h0, rd_val;
	logic master_sm_idle = 1'b1, dma_request_active = 1'b0, device_mode = 1'b0;
	logic dma_mode = 1'b0, suspended = 1'b1, partial_power_down = 1'b1, l1_state = 1'b0;
	logic out_any = 1'b0, in_any = 1'b0, unmask = 1'b0, want_bsess = 1'b0, want_id = 1'b0;
	logic [6:0] evt = 7'h00;
	logic [31:0] reg_rdata;
	logic [4:0] tx_fifo_select;
	logic phy_clk, bsess_valid, conn_id, irq, tx_fifo_flush, rx_fifo_flush;
	logic in_token_queue_flush, bus_domain_soft_reset, core_soft_reset, master_stop, usb_abort;
	integer n_mismatch = 0, checked = 0, seed = 81290, cyc = 0, t0, m, k;
	wire logic [6:0] outs = {usb_abort, master_stop, core_soft_reset, bus_domain_soft_reset,
		in_token_queue_flush, rx_fifo_flush, tx_fifo_flush};

	initial forever #2.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) cyc <= cyc + 1;

	phy_model phy_model_inst (.want_bsess(want_bsess), .want_id(want_id), .phy_clk(phy_clk),
		.bsess_valid(bsess_valid), .conn_id(conn_id));

	usb_core_reset_int usb_core_reset_int_inst (.clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.phy_clk(phy_clk), .bsess_valid(bsess_valid), .conn_id(conn_id),
		.master_sm_idle(master_sm_idle), .dma_request_active(dma_request_active),
		.device_mode(device_mode), .dma_mode(dma_mode), .suspended(suspended),
		.partial_power_down(partial_power_down), .l1_state(l1_state), .resume_evt(evt[0]),
		.l1_wake_evt(evt[1]), .usb_reset_evt(evt[2]), .fetch_stall_evt(evt[3]),
		.iso_out_evt(evt[4]), .iso_in_evt(evt[5]), .periodic_frame_evt(evt[6]),
		.out_endpoint_cause_any(out_any), .in_endpoint_cause_any(in_any),
		.global_interrupt_unmask(unmask), .int_mask(int_mask), .irq(irq),
		.tx_fifo_flush(tx_fifo_flush), .tx_fifo_select(tx_fifo_select),
		.rx_fifo_flush(rx_fifo_flush), .in_token_queue_flush(in_token_queue_flush),
		.bus_domain_soft_reset(bus_domain_soft_reset), .core_soft_reset(core_soft_reset),
		.master_stop(master_stop), .usb_abort(usb_abort));

	// ----------------------------------------------------------------
	// Compare, bus and model tasks
	// ----------------------------------------------------------------
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t value %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t flag %b expected %b", $time, got, exp);
		end
	endtask

	task final_report;
		$display("mismatches %0d checks %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		#1 reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(posedge clk_sys);
		#1 reg_wr = 1'b0;
		if (a == CORE_INTERRUPT_STATUS_OFFSET) status_m = status_m & ~(d & STATUS_STICKY_MASK);
	endtask

	task automatic rd(input logic [11:0] a);
		@(posedge clk_sys);
		#1 reg_rd = 1'b1;
		reg_addr = a;
		@(posedge clk_sys);
		#1 reg_rd = 1'b0;
		rd_val = reg_rdata;
	endtask

	function automatic logic [31:0] st_exp();
		return status_m | 32'h00000020 | {12'h000, out_any, in_any, 18'h0};
	endfunction

	function automatic logic [31:0] ev_exp(input int e);
		case (e)
			0: return 32'h80000000;
			1: return l1_state ? 32'h80000000 : 32'h0;
			2: return (device_mode & suspended & partial_power_down) ? 32'h00800000 : 32'h0;
			3: return dma_mode ? 32'h00400000 : 32'h0;
			4: return 32'h00208000;
			5: return 32'h00108000;
			default: return 32'h00008000;
		endcase
	endfunction

	task automatic pulse(input int e);
		@(posedge clk_sys);
		#1 evt[e] = 1'b1;
		@(posedge clk_sys);
		#1 evt = 7'h00;
		status_m = status_m | ev_exp(e);
	endtask

	task automatic chk_status;
		rd(CORE_INTERRUPT_STATUS_OFFSET);
		chk_reg(rd_val, st_exp());
	endtask

	// Software waits for self-clear before anything else, so the select field stays put.
	task automatic flush(input logic [31:0] d, input int b, input logic [6:0] e,
		input logic [6:0] msk, input logic [31:0] fin);
		int n;
		wr(CORE_RESET_CONTROL_OFFSET, d);
		t0 = cyc;
		repeat (2) @(posedge clk_sys);
		#1 chk_reg({25'h0, outs & msk}, {25'h0, e});
		chk_reg({27'h0, tx_fifo_select}, {27'h0, (b == 0) ? TX_FLUSH_ALL : d[10:6]});
		for (n = 0; n < 200; n++) begin
			rd(CORE_RESET_CONTROL_OFFSET);
			if (rd_val[b] === 1'b0) break;
		end
		if (n == 200) begin
			n_mismatch++;
			$display("ERROR %0t self-clear never came", $time);
			final_report;
		end
		chk_bit(cyc - t0 >= 89, 1'b1);
		chk_reg(rd_val, fin);
		@(posedge clk_sys);
		#1 chk_reg({25'h0, outs}, 32'h0);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (8) @(posedge clk_sys);
		#1 rst = 1'b0;
		rd(CORE_RESET_CONTROL_OFFSET);
		chk_reg(rd_val, CORE_RESET_CONTROL_RESET);
		chk_status;
		rd(12'h018);
		chk_reg(rd_val, 32'h0);
		master_sm_idle = 1'b0;
		dma_request_active = 1'b1;
		repeat (2) @(posedge clk_sys);
		rd(CORE_RESET_CONTROL_OFFSET);
		chk_reg(rd_val, 32'h40000000);
		master_sm_idle = 1'b1;
		dma_request_active = 1'b0;
		for (m = 0; m < 3; m++) begin
			k = (m == 0) ? 0 : (m == 1) ? 15 : 16;
			flush({21'h0, k[4:0], 6'h20}, 5, 7'h01, 7'h7F, {1'b1, 20'h0, k[4:0], 6'h0});
		end
		flush(32'h10, 4, 7'h02, 7'h7F, 32'h80000000);
		flush(32'h08, 3, 7'h04, 7'h7F, 32'h80000000);
		pulse(0);
		// The master stays busy well past the eight-cycle minimum, so the
		// bus-domain reset must wait for it before clearing.
		master_sm_idle = 1'b0;
		fork
			begin
				repeat (150) @(posedge clk_sys);
				#1 master_sm_idle = 1'b1;
			end
		join_none
		flush(32'h02, 1, 7'h28, 7'h7F, 32'h80000000);
		chk_bit(cyc - t0 >= 140, 1'b1);
		chk_status;
		flush(32'h01, 0, 7'h7F, 7'h7F, 32'h80000000);
		status_m = 32'h0;
		chk_status;
		repeat (40) @(posedge clk_sys);
		for (m = 0; m < 3; m++) begin
			device_mode = (m != 0);
			dma_mode = m[0];
			l1_state = m[0];
			suspended = m[0];
			for (k = 0; k < 7; k++) begin
				pulse(k);
				wr(CORE_INTERRUPT_STATUS_OFFSET, 32'h0);
				chk_status;
				wr(CORE_INTERRUPT_STATUS_OFFSET, 32'hFFFFFFFF);
				chk_status;
			end
		end
		@(posedge clk_sys);
		#1 want_bsess = 1'b1;
		repeat (8) @(posedge clk_sys);
		status_m = status_m | 32'h40000000;
		chk_status;
		for (m = 0; m < 2; m++) begin
			want_id = ~want_id;
			repeat (8) @(posedge clk_sys);
			status_m = status_m | 32'h10000000;
			chk_status;
			wr(CORE_INTERRUPT_STATUS_OFFSET, 32'hFFFFFFFF);
		end
		out_any = 1'b1;
		in_any = 1'b1;
		wr(CORE_INTERRUPT_STATUS_OFFSET, 32'hFFFFFFFF);
		chk_status;
		pulse(0);
		for (m = 0; m < 8; m++) begin
			@(posedge clk_sys);
			#1 int_mask = $random(seed) & 32'hFFFFFFDF;
			unmask = 1'($random(seed));
			out_any = 1'($random(seed));
			repeat (3) @(posedge clk_sys);
			#1 chk_bit(irq, unmask & |(st_exp() & int_mask));
		end
		final_report;
	end
endmodule

`default_nettype wire
